// file: rtl/fdcw_regs.vh
// Register offsets, field positions and reset values of the cyclic message handler.
// Assumes an APB slave with 32-bit data; each register is one aligned word.
`ifndef FDCW_REGS_VH
`define FDCW_REGS_VH

// Message shape
`define FDCW_MSG_WORDS 16
`define FDCW_WORD_W 16
`define FDCW_PARAM_WORDS 4
`define FDCW_PD_FIRST 4

// Register byte offsets
`define FDCW_OFF_CFG 12'h000
`define FDCW_OFF_STAT 12'h004
`define FDCW_OFF_NODE 12'h008
`define FDCW_OFF_STATE 12'h00c
`define FDCW_OFF_PWCNT 12'h010
`define FDCW_OFF_RX_BASE 12'h040
`define FDCW_OFF_TX_BASE 12'h080

// Configuration register fields
`define FDCW_CFG_SRC_BIT 0
`define FDCW_CFG_RST 32'h0000_0000
`define FDCW_NODE_RST 7'h02

// Control word fields
`define FDCW_CW_CMD_LSB 0
`define FDCW_CW_CMD_MSB 7
`define FDCW_CW_WREN_BIT 8
`define FDCW_CW_MSET_LSB 9
`define FDCW_CW_MSET_MSB 10
`define FDCW_CW_TORQ_BIT 11
`define FDCW_CW_ECLR_BIT 12
`define FDCW_CW_PREMAG_BIT 13
`define FDCW_CW_DCBRK_BIT 14
`define FDCW_CW_HBEAT_BIT 15

// Command codes
`define FDCW_CMD_FWD 8'h01
`define FDCW_CMD_REV 8'h02
`define FDCW_CMD_JOGF 8'h03
`define FDCW_CMD_JOGR 8'h04
`define FDCW_CMD_DECEL 8'h05
`define FDCW_CMD_COAST 8'h06
`define FDCW_CMD_FRST 8'h07
`define FDCW_CMD_JOGSTOP 8'h08

// Run states
`define FDCW_RUN_STOP 3'h0
`define FDCW_RUN_FWD 3'h1
`define FDCW_RUN_REV 3'h2
`define FDCW_RUN_JOGF 3'h3
`define FDCW_RUN_JOGR 3'h4
`define FDCW_RUN_DECEL 3'h5

// State word fields
`define FDCW_SW_RUN_LSB 0
`define FDCW_SW_RUN_MSB 2
`define FDCW_SW_SRC_BIT 8
`define FDCW_SW_MSET_LSB 9
`define FDCW_SW_MSET_MSB 10
`define FDCW_SW_TORQ_BIT 11
`define FDCW_SW_PREMAG_BIT 12
`define FDCW_SW_DCBRK_BIT 13
`define FDCW_SW_HBEAT_BIT 14
`define FDCW_SW_WPERM_BIT 15

`endif

// file: rtl/fdcw_cmd_decode.v
// Control word decoder: run state machine and single-bit function enables.
// Assumes cw_valid is a one-cycle pulse carrying an accepted control word.
`timescale 1ns/100ps
`include "fdcw_regs.vh"

module fdcw_cmd_decode (
    input wire pclk,
    input wire presetn,
    input wire cw_valid,
    input wire [15:0] control_word,
    output reg [2:0] run_state_reg,
    output reg fault_reset_reg,
    output reg param_write_permit_reg,
    output reg [1:0] motor_set_reg,
    output reg torque_mode_reg,
    output reg energy_clear_reg,
    output reg pre_magnetize_reg,
    output reg dc_injection_brake_reg,
    output reg heartbeat_en_reg
);
    wire [7:0] cmd = control_word[`FDCW_CW_CMD_MSB:`FDCW_CW_CMD_LSB];
    reg [2:0] run_state_next;

    // Next run state from the command code
    always @* begin
        run_state_next = run_state_reg;
        case (cmd)
            `FDCW_CMD_FWD: run_state_next = `FDCW_RUN_FWD;
            `FDCW_CMD_REV: run_state_next = `FDCW_RUN_REV;
            `FDCW_CMD_JOGF: run_state_next = `FDCW_RUN_JOGF;
            `FDCW_CMD_JOGR: run_state_next = `FDCW_RUN_JOGR;
            `FDCW_CMD_DECEL: run_state_next = `FDCW_RUN_DECEL;
            `FDCW_CMD_COAST: run_state_next = `FDCW_RUN_STOP;
            `FDCW_CMD_FRST: run_state_next = run_state_reg;
            `FDCW_CMD_JOGSTOP: begin
                // Jog stop only ends a jog; a normal run keeps going
                if (run_state_reg == `FDCW_RUN_JOGF || run_state_reg == `FDCW_RUN_JOGR) begin
                    run_state_next = `FDCW_RUN_STOP;
                end
            end
            default: run_state_next = run_state_reg;
        endcase
    end

    // Latch the decoded fields on each accepted control word
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_state_reg <= `FDCW_RUN_STOP;
            fault_reset_reg <= 1'b0;
            param_write_permit_reg <= 1'b0;
            motor_set_reg <= 2'h0;
            torque_mode_reg <= 1'b0;
            energy_clear_reg <= 1'b0;
            pre_magnetize_reg <= 1'b0;
            dc_injection_brake_reg <= 1'b0;
            heartbeat_en_reg <= 1'b0;
        end else begin
            fault_reset_reg <= 1'b0;
            if (cw_valid) begin
                run_state_reg <= run_state_next;
                fault_reset_reg <= (cmd == `FDCW_CMD_FRST);
                param_write_permit_reg <= control_word[`FDCW_CW_WREN_BIT];
                motor_set_reg <= control_word[`FDCW_CW_MSET_MSB:`FDCW_CW_MSET_LSB];
                torque_mode_reg <= control_word[`FDCW_CW_TORQ_BIT];
                energy_clear_reg <= control_word[`FDCW_CW_ECLR_BIT];
                pre_magnetize_reg <= control_word[`FDCW_CW_PREMAG_BIT];
                dc_injection_brake_reg <= control_word[`FDCW_CW_DCBRK_BIT];
                heartbeat_en_reg <= control_word[`FDCW_CW_HBEAT_BIT];
            end
        end
    end
endmodule

// file: rtl/fdcw_msg_handler.v
// Cyclic message handler: takes a 16-word message stream, splits the parameter
// and process-data areas, decodes the control word and returns the reply stream.
// Assumes words arrive synchronous to pclk, framed by a start-of-message strobe;
// the physical layer and frame check sit outside.
`timescale 1ns/100ps
`include "fdcw_regs.vh"

module fdcw_msg_handler #(
    parameter MSG_WORDS = `FDCW_MSG_WORDS
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire [11:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Message stream from the link layer
    input wire rx_sof,
    input wire rx_valid,
    input wire [6:0] rx_addr,
    input wire [15:0] rx_word,
    // Reply stream back to the link layer
    output reg tx_valid,
    output reg [15:0] tx_word,
    output reg tx_last,
    output reg msg_done,
    // Parameter area handed to the drive
    output reg param_wr_strobe,
    output reg [15:0] parameter_id_word,
    output reg [15:0] array_index_word,
    output reg [15:0] parameter_value_one,
    output reg [15:0] parameter_value_two,
    // Decoded control word
    output wire [2:0] run_state,
    output wire fault_reset,
    output wire [1:0] motor_set,
    output wire torque_mode,
    output wire energy_clear,
    output wire pre_magnetize,
    output wire dc_injection_brake,
    output wire heartbeat_en,
    // Frequency given value
    output reg [15:0] freq_set_centihz
);
    // Register indexes into the word arrays
    function [3:0] word_idx;
        input [11:0] a;
        begin
            word_idx = a[5:2];
        end
    endfunction

    // Word windows sit on 64-byte boundaries; the upper address bits pick the window
    function in_window;
        input [11:0] a;
        input [11:0] base;
        begin
            in_window = (a[11:6] == base[11:6]);
        end
    endfunction

    // Received words are staged and committed whole; reply words 5 to 15 come from software
    reg [31:0] cfg_reg;
    reg [6:0] node_reg;
    reg [15:0] pwcnt_reg;
    reg [15:0] rx_mem [0:15];
    reg [15:0] tx_mem [0:15];
    reg [15:0] stage_mem [0:15];
    reg [3:0] rx_cnt_reg;
    reg rx_act_reg;
    reg [3:0] tx_cnt_reg;
    reg tx_act_reg;
    reg cw_valid_reg;
    reg [15:0] cw_reg;
    reg [15:0] state_word;
    wire param_write_permit;
    reg [15:0] tx_word_next;
    integer i;
    integer j;

    // Bus qualifiers and link address match
    wire apb_wr = psel & penable & pwrite;
    wire apb_rd_setup = psel & ~penable & ~pwrite;
    wire src_bus = cfg_reg[`FDCW_CFG_SRC_BIT];
    wire addr_hit = rx_addr == node_reg;

    // Zero-wait APB slave; unmapped reads return zero
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // Configuration and actual-value registers written by software
    // Writes land only in the access phase, the one edge with psel, penable and pwrite high
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= `FDCW_CFG_RST;
            node_reg <= `FDCW_NODE_RST;
            for (i = 0; i < 16; i = i + 1) begin
                tx_mem[i] <= 16'h0000;
            end
        end else if (apb_wr) begin
            if (paddr == `FDCW_OFF_CFG) begin
                cfg_reg <= {31'h0, pwdata[0]};
            end
            if (paddr == `FDCW_OFF_NODE) begin
                node_reg <= pwdata[6:0];
            end
            if (in_window(paddr, `FDCW_OFF_TX_BASE)) begin
                tx_mem[word_idx(paddr)] <= pwdata[15:0];
            end
        end
    end

    // Read data registered in the setup phase so it is stable in access
    // Costs the setup cycle, but keeps the wide read mux off the access-phase path
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (apb_rd_setup) begin
            if (paddr == `FDCW_OFF_CFG) begin
                prdata <= cfg_reg;
            end else if (paddr == `FDCW_OFF_STAT) begin
                prdata <= {21'h0, rx_act_reg, tx_act_reg, param_write_permit, motor_set,
                           torque_mode, heartbeat_en, pre_magnetize, run_state};
            end else if (paddr == `FDCW_OFF_NODE) begin
                prdata <= {25'h0, node_reg};
            end else if (paddr == `FDCW_OFF_STATE) begin
                prdata <= {16'h0, state_word};
            end else if (paddr == `FDCW_OFF_PWCNT) begin
                prdata <= {16'h0, pwcnt_reg};
            end else if (in_window(paddr, `FDCW_OFF_RX_BASE)) begin
                prdata <= {16'h0, rx_mem[word_idx(paddr)]};
            end else if (in_window(paddr, `FDCW_OFF_TX_BASE)) begin
                prdata <= {16'h0, tx_mem[word_idx(paddr)]};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Receive: count sixteen words of a message addressed to this node
    // A new start strobe always restarts the count, so a cut frame is simply dropped
    // Messages for other stations leave the staged words untouched
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_cnt_reg <= 4'h0;
            rx_act_reg <= 1'b0;
            msg_done <= 1'b0;
            for (j = 0; j < 16; j = j + 1) begin
                stage_mem[j] <= 16'h0000;
                rx_mem[j] <= 16'h0000;
            end
        end else begin
            msg_done <= 1'b0;
            if (rx_sof) begin
                rx_act_reg <= addr_hit;
                rx_cnt_reg <= 4'h0;
            end else if (rx_act_reg && rx_valid) begin
                stage_mem[rx_cnt_reg] <= rx_word;
                rx_cnt_reg <= rx_cnt_reg + 4'h1;
                if (rx_cnt_reg == MSG_WORDS - 1) begin
                    rx_act_reg <= 1'b0;
                    msg_done <= 1'b1;
                    // Whole message committed at once so a short frame never half-applies
                    for (j = 0; j < 15; j = j + 1) begin
                        rx_mem[j] <= stage_mem[j];
                    end
                    rx_mem[15] <= rx_word;
                end
            end
        end
    end

    // Process data first: control word goes to the decoder before parameters
    // Given values obey the source bit too, so a local command source is never overridden
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cw_valid_reg <= 1'b0;
            cw_reg <= 16'h0000;
            freq_set_centihz <= 16'h0000;
        end else begin
            cw_valid_reg <= 1'b0;
            if (msg_done && src_bus) begin
                cw_valid_reg <= 1'b1;
                cw_reg <= rx_mem[`FDCW_PD_FIRST];
                freq_set_centihz <= rx_mem[`FDCW_PD_FIRST + 1];
            end
        end
    end

    // Parameter area handled a cycle after the control word it depends on
    // Write permit comes from the same message, never from an older control word
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            param_wr_strobe <= 1'b0;
            parameter_id_word <= 16'h0000;
            array_index_word <= 16'h0000;
            parameter_value_one <= 16'h0000;
            parameter_value_two <= 16'h0000;
            pwcnt_reg <= 16'h0000;
        end else begin
            param_wr_strobe <= 1'b0;
            if (cw_valid_reg && cw_reg[`FDCW_CW_WREN_BIT]) begin
                param_wr_strobe <= 1'b1;
                parameter_id_word <= rx_mem[0];
                array_index_word <= rx_mem[1];
                parameter_value_one <= rx_mem[2];
                parameter_value_two <= rx_mem[3];
                pwcnt_reg <= pwcnt_reg + 16'h1;
            end
        end
    end

    fdcw_cmd_decode u_dec (
        .pclk(pclk),
        .presetn(presetn),
        .cw_valid(cw_valid_reg),
        .control_word(cw_reg),
        .run_state_reg(run_state),
        .fault_reset_reg(fault_reset),
        .param_write_permit_reg(param_write_permit),
        .motor_set_reg(motor_set),
        .torque_mode_reg(torque_mode),
        .energy_clear_reg(energy_clear),
        .pre_magnetize_reg(pre_magnetize),
        .dc_injection_brake_reg(dc_injection_brake),
        .heartbeat_en_reg(heartbeat_en)
    );

    // State word reflects the condition that the control word produced
    // Energy clear has no state word bit; it only reaches the drive pin
    always @* begin
        state_word = 16'h0000;
        state_word[`FDCW_SW_RUN_MSB:`FDCW_SW_RUN_LSB] = run_state;
        state_word[`FDCW_SW_SRC_BIT] = src_bus;
        state_word[`FDCW_SW_MSET_MSB:`FDCW_SW_MSET_LSB] = motor_set;
        state_word[`FDCW_SW_TORQ_BIT] = torque_mode;
        state_word[`FDCW_SW_PREMAG_BIT] = pre_magnetize;
        state_word[`FDCW_SW_DCBRK_BIT] = dc_injection_brake;
        state_word[`FDCW_SW_HBEAT_BIT] = heartbeat_en;
        state_word[`FDCW_SW_WPERM_BIT] = param_write_permit;
    end

    // Reply word source: echoed parameter area, state word or actual values
    always @* begin
        if (tx_cnt_reg == `FDCW_PD_FIRST) begin
            tx_word_next = state_word;
        end else if (tx_cnt_reg < `FDCW_PARAM_WORDS) begin
            tx_word_next = rx_mem[tx_cnt_reg];
        end else begin
            tx_word_next = tx_mem[tx_cnt_reg];
        end
    end

    // Reply: sixteen words after each accepted message, current values always
    // Reply starts only after a whole message, so its echo never mixes two messages
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_act_reg <= 1'b0;
            tx_cnt_reg <= 4'h0;
            tx_valid <= 1'b0;
            tx_word <= 16'h0000;
            tx_last <= 1'b0;
        end else begin
            tx_valid <= 1'b0;
            tx_last <= 1'b0;
            if (msg_done) begin
                tx_act_reg <= 1'b1;
                tx_cnt_reg <= 4'h0;
            end else if (tx_act_reg) begin
                tx_valid <= 1'b1;
                tx_word <= tx_word_next;
                tx_cnt_reg <= tx_cnt_reg + 4'h1;
                if (tx_cnt_reg == MSG_WORDS - 1) begin
                    tx_act_reg <= 1'b0;
                    tx_last <= 1'b1;
                end
            end
        end
    end
endmodule

// file: dv/fdcw_checker.sv
// Checker bound to the cyclic message handler: reply framing and decode timing.
// Assumes one clock domain, pclk, with presetn as its asynchronous reset.
`timescale 1ns/100ps
module fdcw_checker (
    input wire pclk,
    input wire presetn,
    input wire tx_valid,
    input wire [15:0] tx_word,
    input wire tx_last,
    input wire msg_done,
    input wire param_wr_strobe,
    input wire [2:0] run_state,
    input wire fault_reset,
    input wire [1:0] motor_set,
    input wire torque_mode,
    input wire energy_clear,
    input wire pre_magnetize,
    input wire dc_injection_brake,
    input wire heartbeat_en
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    reg [4:0] tx_pos_reg;
    wire [6:0] levels;
    // Index of the reply word now on the link
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            tx_pos_reg <= 5'h00;
        else
            tx_pos_reg <= tx_valid ? tx_pos_reg + 5'h01 : 5'h00;
    end
    // Decoded levels share one update edge, so they are watched as a group
    assign levels = {motor_set, torque_mode, energy_clear, pre_magnetize,
        dc_injection_brake, heartbeat_en};
    sequence half_burst;
        tx_valid [*8];
    endsequence
    sequence burst_tail;
        tx_last ##1 !tx_valid;
    endsequence
    reply_len_a: assert property ($rose(tx_valid) |-> half_burst ##1 half_burst ##0 burst_tail)
        else $error("reply burst not sixteen words");
    last_pos_a: assert property (tx_last |-> tx_valid && tx_pos_reg == 5'h0f)
        else $error("last flag off the final word");
    done_pulse_a: assert property (msg_done |=> !msg_done [*8])
        else $error("message done repeats too soon");
    reply_start_a: assert property (msg_done |-> ##[1:2] $rose(tx_valid))
        else $error("reply did not follow message");
    state_word_a: assert property (tx_valid && tx_pos_reg == 5'h04 |-> tx_word[14:0] ==
        {heartbeat_en, dc_injection_brake, pre_magnetize, torque_mode, motor_set, tx_word[8],
        5'h00, run_state}) else $error("state word disagrees with decoded state");
    run_change_a: assert property (!$stable(run_state) |-> $past(msg_done, 2))
        else $error("run state moved without a message");
    level_change_a: assert property (!$stable(levels) |-> $past(msg_done, 2))
        else $error("enable levels moved without a message");
    strobe_time_a: assert property (param_wr_strobe |-> $past(msg_done, 2))
        else $error("parameter write outside decode slot");
    fault_pulse_a: assert property (fault_reset |-> $past(msg_done, 2) ##1 !fault_reset)
        else $error("fault reset pulse misplaced");
endmodule

bind fdcw_msg_handler fdcw_checker fdcw_checker_inst (.pclk, .presetn, .tx_valid, .tx_word,
    .tx_last, .msg_done, .param_wr_strobe, .run_state, .fault_reset, .motor_set, .torque_mode,
    .energy_clear, .pre_magnetize, .dc_injection_brake, .heartbeat_en);

// file: dv/fdcw_mstr.sv
// Bus master model: sends cyclic messages and gathers the reply words.
// Assumes the bench fills msg before send_msg and then waits for got_last.
`timescale 1ns/100ps
module fdcw_mstr (
    input wire pclk,
    output logic rx_sof,
    output logic rx_valid,
    output logic [6:0] rx_addr,
    output logic [15:0] rx_word,
    input wire tx_valid,
    input wire [15:0] tx_word,
    input wire tx_last
);
    logic [15:0] msg [0:15];
    logic [15:0] reply [0:15];
    logic [4:0] tx_idx = 5'h00;
    logic got_last = 1'b0;
    // Idle link: nothing offered, address of no station in use
    initial begin
        rx_sof = 1'b0;
        rx_valid = 1'b0;
        rx_addr = 7'h7f;
        rx_word = 16'h0000;
    end
    // Reply words in link order; the index tells how many arrived
    always @(posedge pclk) begin
        if (tx_valid === 1'b1) begin
            reply[tx_idx[3:0]] <= tx_word;
            tx_idx <= tx_idx + 5'h01;
            got_last <= got_last | tx_last;
        end
    end
    // Start strobe with address, then n words; released lines show inverted data
    task send_msg(input logic [6:0] addr, input int n, input bit gap);
        @(posedge pclk);
        tx_idx <= 5'h00;
        got_last <= 1'b0;
        rx_sof <= 1'b1;
        rx_addr <= addr;
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            rx_sof <= 1'b0;
            rx_addr <= ~addr;
            rx_valid <= 1'b1;
            rx_word <= msg[i];
            if (gap) begin
                @(posedge pclk);
                rx_valid <= 1'b0;
                rx_word <= ~msg[i];
            end
        end
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_word <= ~rx_word;
    endtask
endmodule

// file: dv/tb.sv
// Self-checking bench for the cyclic message handler with a bus master model.
// Assumes the checker binds itself and the model is compiled first.
`timescale 1ns/100ps
`include "fdcw_regs.vh"
module tb;
    logic pclk, presetn, psel, penable, pwrite, src, saw_done, saw_strobe, saw_fault;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    logic [15:0] txv [0:15];
    logic [15:0] cw;
    logic [7:0] hi_bits = 8'h00;
    logic [2:0] run_exp = 3'h0;
    logic [15:0] pw_exp = 16'h0000;
    wire [31:0] prdata;
    wire pready, pslverr, rx_sof, rx_valid, tx_valid, tx_last, msg_done, param_wr_strobe;
    wire fault_reset, torque_mode, energy_clear, pre_magnetize, dc_injection_brake;
    wire heartbeat_en;
    wire [6:0] rx_addr;
    wire [2:0] run_state;
    wire [1:0] motor_set;
    wire [15:0] rx_word, tx_word, parameter_id_word, array_index_word, parameter_value_one;
    wire [15:0] parameter_value_two, freq_set_centihz;
    int fails = 0, samples_checked = 0, cyc = 0, i, j, k;
    fdcw_msg_handler fdcw_msg_handler_inst (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .rx_sof, .rx_valid, .rx_addr, .rx_word, .tx_valid,
        .tx_word, .tx_last, .msg_done, .param_wr_strobe, .parameter_id_word, .array_index_word,
        .parameter_value_one, .parameter_value_two, .run_state, .fault_reset, .motor_set,
        .torque_mode, .energy_clear, .pre_magnetize, .dc_injection_brake, .heartbeat_en,
        .freq_set_centihz);
    fdcw_mstr fdcw_mstr_inst (.pclk, .rx_sof, .rx_valid, .rx_addr, .rx_word, .tx_valid,
        .tx_word, .tx_last);
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // Pulses are latched so checks may look after the reply; a hang ends the run
    always @(posedge pclk) begin
        cyc++;
        if (msg_done === 1'b1) saw_done = 1'b1;
        if (param_wr_strobe === 1'b1) saw_strobe = 1'b1;
        if (fault_reset === 1'b1) saw_fault = 1'b1;
        if (cyc == 6000) begin
            fails++;
            tally_and_finish();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task tally_and_finish;
        if (fails == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // One APB transfer; read data is taken at the completing edge
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, paddr, pwrite, pwdata} <= {2'b10, a, w, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        {psel, penable} <= 2'b00;
    endtask
    // Codes one to five map straight onto run states; jog stop ends only a jog
    function logic [2:0] next_run(input logic [2:0] r, input logic [7:0] c);
        case (c)
            8'h01, 8'h02, 8'h03, 8'h04, 8'h05: next_run = c[2:0];
            8'h06: next_run = 3'h0;
            8'h08: next_run = (r == 3'h3 || r == 3'h4) ? 3'h0 : r;
            default: next_run = r;
        endcase
    endfunction
    task fill(input int code);
        for (j = 0; j < 16; j++) fdcw_mstr_inst.msg[j] = 16'($urandom);
        cw = 16'($urandom);
        if (code >= 0) cw[7:0] = 8'(code);
        fdcw_mstr_inst.msg[4] = cw;
    endtask
    task run_msg(input logic [6:0] addr, input bit gap);
        {saw_done, saw_strobe, saw_fault} = 3'h0;
        fdcw_mstr_inst.send_msg(addr, 16, gap);
        for (i = 0; i < 40 && fdcw_mstr_inst.got_last !== 1'b1; i++) @(posedge pclk);
        repeat (2) @(posedge pclk);
    endtask
    task check_msg;
        logic [15:0] sw;
        logic [63:0] pa;
        sw = {hi_bits[0], hi_bits[7:5], hi_bits[3:1], src, 5'h00, run_exp};
        pa = {fdcw_mstr_inst.msg[0], fdcw_mstr_inst.msg[1], fdcw_mstr_inst.msg[2],
            fdcw_mstr_inst.msg[3]};
        chk({saw_done, fdcw_mstr_inst.tx_idx}, {1'b1, 5'h10});
        for (j = 0; j < 16; j++)
            chk(fdcw_mstr_inst.reply[j], j == 4 ? sw : j < 4 ? pa[63-16*j -: 16] : txv[j]);
        chk(run_state, run_exp);
        chk({motor_set, torque_mode, energy_clear, pre_magnetize, dc_injection_brake},
            {hi_bits[2:1], hi_bits[3], hi_bits[4], hi_bits[5], hi_bits[6]});
        chk(heartbeat_en, hi_bits[7]);
        chk({saw_strobe, saw_fault}, {src & cw[8], src & (cw[7:0] == 8'h07)});
        if (src) chk(freq_set_centihz, fdcw_mstr_inst.msg[5]);
        if (src & cw[8]) chk({parameter_id_word, array_index_word}, pa[63:32]);
        if (src & cw[8]) chk({parameter_value_one, parameter_value_two}, pa[31:0]);
        if (src & cw[8]) pw_exp++;
        apb(`FDCW_OFF_STATE, 1'b0, 32'h0);
        chk(rd, {16'h0000, sw});
        apb(`FDCW_OFF_STAT, 1'b0, 32'h0);
        chk(rd, {23'h000000, hi_bits[0], hi_bits[2:1], hi_bits[3], hi_bits[7], hi_bits[5],
            run_exp});
        apb(`FDCW_OFF_PWCNT, 1'b0, 32'h0);
        chk(rd, {16'h0000, pw_exp});
        j = $urandom % 16;
        apb(12'(`FDCW_OFF_RX_BASE + 4 * j), 1'b0, 32'h0);
        chk(rd, {16'h0000, fdcw_mstr_inst.msg[j]});
    endtask
    initial begin
        void'($urandom(32'h161e));
        {psel, penable, pwrite, paddr, pwdata, src} = '0;
        presetn = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(`FDCW_OFF_CFG, 1'b0, 32'h0);
        chk(rd, 32'h0);
        apb(`FDCW_OFF_NODE, 1'b0, 32'h0);
        chk(rd, 32'h2);
        apb(12'h020, 1'b0, 32'h0);
        chk(rd, 32'h0);
        chk({pready, pslverr}, 32'h2);
        for (i = 5; i < 16; i++) begin
            txv[i] = 16'($urandom);
            apb(12'(`FDCW_OFF_TX_BASE + 4 * i), 1'b1, {16'h0000, txv[i]});
        end
        // Fieldbus not the command source: nothing decoded, reply still sent
        fill(1);
        run_msg(7'h02, 1'b0);
        check_msg();
        apb(`FDCW_OFF_CFG, 1'b1, 32'h1);
        src = 1'b1;
        // Every code from zero to nine, then random words; a partial frame midway
        for (k = 0; k < 24; k++) begin
            fill(k < 10 ? k : -1);
            if (k == 12) fdcw_mstr_inst.send_msg(7'h02, 6, 1'b0);
            run_msg(7'h02, k[0]);
            run_exp = next_run(run_exp, cw[7:0]);
            hi_bits = cw[15:8];
            check_msg();
        end
        // A message for another station leaves everything alone
        fill(1);
        run_msg(7'h03, 1'b0);
        chk({saw_done, fdcw_mstr_inst.got_last, run_state}, {2'h0, run_exp});
        tally_and_finish();
    end
endmodule
